// ### hw/upc_port_ctrl.v
// Per-port UTOPIA control registers and cell delineator interrupt logic, APB slave.
// Assumes synchronous status inputs from the cell logic and a single 250 MHz clock.
// How it works
// - Writing 1 to transmit reset pulses a transmit FIFO pointer clear.
// - Writing 1 to receive reset pulses a receive FIFO pointer clear.
// - Parity sense 1 selects even parity, 0 odd, for generate and check.
// - Fill code 00..11 means cell-available shows full after 1..4 more cells.
// - Output disable blocks all UTOPIA outputs; it is 1 after reset.
// - Port answers only when address pins equal its five-bit address.
// - Address resets to top bit 0 and low four bits the port index.
// - In 16-bit mode the UDF2 octet register is inserted; defaults to port.
// - Indication bits latch events only when their enable bit is set.
// - Summary tx/rx bits show any latched bit when enable bits 1/0 are set, clear when register read-cleared.
// - Summary bit 4 carries the convergence interrupt, gated by enable bit 4.
// - Summary interrupt reaches port status with the CDEN and PORTEN enables; the pin also needs PINEN.
// - Transmit enable bits 7..2 select six transmit events; reset FC.
// - Receive enable bits 7..0 select seven receive events, bit 4 reserved; reset FF.
// - Enabled cell interrupts combine onto the port delineator interrupt bit.
// - Transmit indications set on rising status edge; reading clears them.
// - Receive indication layout: LOCD, HEC det, HEC corr, reserved, then four.
// - Loss-of-delineation latches on either edge when enabled; read clears.
// - Lowest receive indication bit reports a non-zero flow field cell.
// - Bus conflict status asserts when another port shares this address.
`include "upc_map.vh"

module upc_port_ctrl #(
    parameter [3:0] PORT_INDEX = 4'h0
) (
    input  wire        clock,
    input  wire        arst_n,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output wire        pready,
    output reg  [31:0] prdata,
    output wire        pslverr,
    input  wire [5:0]  tx_status,
    input  wire [7:0]  rx_status,
    input  wire [4:0]  other_port_address,
    input  wire        other_port_valid,
    input  wire        convergence_frame_irq,
    input  wire [4:0]  tx_address_pins,
    input  wire [4:0]  rx_address_pins,
    output wire        tx_port_selected,
    output wire        rx_port_selected,
    output wire        utopia_output_enable,
    output wire        tx_fifo_pointer_clear,
    output wire        rx_fifo_pointer_clear,
    output wire        parity_sense_select,
    output wire [1:0]  tx_fill_threshold,
    output wire [2:0]  tx_fill_cells_minus_one,
    output wire [7:0]  rx_user_octet_two,
    output wire        rx_user_octet_insert,
    output wire        delineator_port_irq,
    output wire        port_summary_status,
    output wire        irq_pin_n,
    output wire        bus_conflict_status
);

    // ----------------------------------------
    // Register state
    // ----------------------------------------
    reg  [7:0] sum_en_q;
    reg  [7:0] uctl_one_q;
    reg  [5:0] uctl_two_q;
    reg  [7:0] udf2_q;
    reg  [7:0] tx_en_q;
    reg  [7:0] rx_en_q;
    reg  [7:0] tx_ind_q;
    reg  [7:0] rx_ind_q;
    reg  [7:0] tx_stat_q;
    reg  [7:0] rx_stat_q;
    reg  [3:0] port_ctl_q;
    reg        tx_clr_q;
    reg        rx_clr_q;
    reg  [7:0] tx_ind_d;
    reg  [7:0] rx_ind_d;

    wire [7:0] tx_src;
    wire [7:0] rx_src;
    wire [7:0] tx_rise;
    wire [7:0] rx_event;
    wire [7:0] sum_ind;
    wire [7:0] reg_index;
    wire       wr_en;
    wire       rd_en;
    wire       sum_active;

    function hit;
        input [7:0] idx;
        input [7:0] want;
        begin
            hit = (idx == want);
        end
    endfunction

    // ----------------------------------------
    // APB decode
    // ----------------------------------------
    // Zero wait states; only paddr[9:2] is decoded, so unmapped indices read zero and paddr[11:10] alias; no error is signalled.
    assign pready    = 1'b1;
    assign pslverr   = 1'b0;
    assign reg_index = paddr[9:2];
    assign wr_en     = psel & penable & pwrite;
    assign rd_en     = psel & penable & ~pwrite;

    // ----------------------------------------
    // Event sources
    // ----------------------------------------
    // Bus conflict is driven here rather than taken from outside.
    assign bus_conflict_status = other_port_valid & (other_port_address == uctl_two_q[`UPC_F_ADDR]);
    assign tx_src   = {tx_status[5:1], bus_conflict_status, 2'b00};
    assign rx_src   = {rx_status[7:5], 1'b0, rx_status[3:0]};
    assign tx_rise  = tx_src & ~tx_stat_q;
    // LOCD is dual-event; the rest are single-event rising edges.
    assign rx_event = (rx_src & ~rx_stat_q) |
                      ((rx_src ^ rx_stat_q) & (8'h01 << `UPC_B_LOCD));

    always @* begin
        tx_ind_d = tx_ind_q;
        rx_ind_d = rx_ind_q;
        // Read clears first; a coincident event wins so it is never lost.
        if (rd_en && hit(reg_index, `UPC_IDX_TXIND)) begin
            tx_ind_d = `UPC_ZERO8;
        end
        if (rd_en && hit(reg_index, `UPC_IDX_RXIND)) begin
            rx_ind_d = `UPC_ZERO8;
        end
        tx_ind_d = tx_ind_d | (tx_rise & tx_en_q & `UPC_M_TXIND);
        rx_ind_d = rx_ind_d | (rx_event & rx_en_q & `UPC_M_RXIND);
    end

    // ----------------------------------------
    // Summary and port interrupt
    // ----------------------------------------
    assign sum_ind = {3'b000, convergence_frame_irq & sum_en_q[`UPC_B_PLCP], 2'b00,
                      (|tx_ind_q) & sum_en_q[`UPC_B_TXSUM],
                      (|rx_ind_q) & sum_en_q[`UPC_B_RXSUM]};
    assign sum_active          = |sum_ind;
    assign delineator_port_irq = sum_active & port_ctl_q[`UPC_B_CDEN];
    assign port_summary_status = delineator_port_irq & port_ctl_q[`UPC_B_PORTEN];
    assign irq_pin_n           = ~(port_summary_status & port_ctl_q[`UPC_B_PINEN]);

    // ----------------------------------------
    // UTOPIA side controls
    // ----------------------------------------
    // Changing these while traffic runs is a software fault; no guard is built in.
    assign utopia_output_enable    = ~uctl_two_q[`UPC_B_UDIS];
    assign tx_port_selected        = (tx_address_pins == uctl_two_q[`UPC_F_ADDR]);
    assign rx_port_selected        = (rx_address_pins == uctl_two_q[`UPC_F_ADDR]);
    assign parity_sense_select     = uctl_one_q[`UPC_B_PARITY];
    assign tx_fill_threshold       = uctl_one_q[`UPC_F_FILL];
    assign tx_fill_cells_minus_one = {1'b0, uctl_one_q[`UPC_F_FILL]};
    assign rx_user_octet_two       = udf2_q;
    assign rx_user_octet_insert    = port_ctl_q[`UPC_B_UTOP16];
    assign tx_fifo_pointer_clear   = tx_clr_q;
    assign rx_fifo_pointer_clear   = rx_clr_q;

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    always @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            sum_en_q   <= `UPC_RST_SUMEN;
            uctl_one_q <= `UPC_RST_UCTL_ONE;
            // The port index is a parameter, so these stay constant reset loads.
            uctl_two_q <= {`UPC_RST_UCTL_TWO_HI, PORT_INDEX};
            udf2_q     <= {`UPC_RST_UDF2_HI, PORT_INDEX};
            tx_en_q    <= `UPC_RST_TXEN;
            rx_en_q    <= `UPC_RST_RXEN;
            tx_ind_q   <= `UPC_ZERO8;
            rx_ind_q   <= `UPC_ZERO8;
            tx_stat_q  <= `UPC_ZERO8;
            rx_stat_q  <= `UPC_ZERO8;
            port_ctl_q <= 4'h0;
            tx_clr_q   <= 1'b0;
            rx_clr_q   <= 1'b0;
        end else begin
            tx_ind_q  <= tx_ind_d;
            rx_ind_q  <= rx_ind_d;
            tx_stat_q <= tx_src;
            rx_stat_q <= rx_src;
            tx_clr_q  <= wr_en && hit(reg_index, `UPC_IDX_UCTL_ONE) && pwdata[`UPC_B_TXRST];
            rx_clr_q  <= wr_en && hit(reg_index, `UPC_IDX_UCTL_ONE) && pwdata[`UPC_B_RXRST];
            if (wr_en) begin
                case (reg_index)
                    `UPC_IDX_SUM_EN:    sum_en_q   <= pwdata[7:0] & `UPC_M_SUMEN;
                    `UPC_IDX_UCTL_ONE:  uctl_one_q <= {2'b00, 3'b000, pwdata[2:0]};
                    `UPC_IDX_UCTL_TWO:  uctl_two_q <= pwdata[5:0];
                    `UPC_IDX_UDF2:      udf2_q     <= pwdata[7:0];
                    `UPC_IDX_TXEN:      tx_en_q    <= pwdata[7:0] & `UPC_M_TXIND;
                    `UPC_IDX_RXEN:      rx_en_q    <= pwdata[7:0];
                    `UPC_IDX_PORTCTL:   port_ctl_q <= pwdata[3:0];
                    default: ;
                endcase
            end
        end
    end

    // ----------------------------------------
    // Read mux
    // ----------------------------------------
    always @* begin
        prdata = 32'h0000_0000;
        case (reg_index)
            `UPC_IDX_SUM_IND:    prdata[7:0] = sum_ind;
            `UPC_IDX_SUM_EN:     prdata[7:0] = sum_en_q;
            `UPC_IDX_UCTL_ONE:   prdata[7:0] = uctl_one_q;
            `UPC_IDX_UCTL_TWO:   prdata[5:0] = uctl_two_q;
            `UPC_IDX_UDF2:       prdata[7:0] = udf2_q;
            `UPC_IDX_TXEN:       prdata[7:0] = tx_en_q;
            `UPC_IDX_RXEN:       prdata[7:0] = rx_en_q;
            `UPC_IDX_TXIND:      prdata[7:0] = tx_ind_q;
            `UPC_IDX_RXIND:      prdata[7:0] = rx_ind_q;
            `UPC_IDX_TXSTAT:     prdata[7:0] = tx_stat_q;
            `UPC_IDX_RXSTAT:     prdata[7:0] = rx_stat_q;
            `UPC_IDX_PORTCTL:    prdata[3:0] = port_ctl_q;
            default:             prdata = 32'h0000_0000;
        endcase
    end

endmodule // upc_port_ctrl

// ### hw/upc_map.vh
// Constants for the per-port UTOPIA control and cell interrupt block.
// Assumes a 32-bit APB slave with one register per aligned word.
`ifndef UPC_MAP_VH
`define UPC_MAP_VH
// ----------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------
`define UPC_IDX_SUM_IND      8'h00
`define UPC_IDX_SUM_EN       8'h01
`define UPC_IDX_UCTL_ONE     8'h0D
`define UPC_IDX_UCTL_TWO     8'h0E
`define UPC_IDX_UDF2         8'h0F
`define UPC_IDX_TXEN         8'h28
`define UPC_IDX_RXEN         8'h29
`define UPC_IDX_TXIND        8'h2C
`define UPC_IDX_RXIND        8'h2D
`define UPC_IDX_TXSTAT       8'h2E
`define UPC_IDX_RXSTAT       8'h2F
`define UPC_IDX_PORTCTL      8'h40
// ----------------------------------------
// Reset values
// ----------------------------------------
`define UPC_RST_SUMEN        8'h00
`define UPC_RST_UCTL_ONE     8'h00
`define UPC_RST_TXEN         8'hFC
`define UPC_RST_RXEN         8'hFF
`define UPC_RST_PORTCTL      8'h00
`define UPC_RST_UCTL_TWO_HI  2'b10
`define UPC_RST_UDF2_HI      4'h0
`define UPC_ZERO8            8'h00
// ----------------------------------------
// Field positions
// ----------------------------------------
`define UPC_B_TXRST          7
`define UPC_B_RXRST          6
`define UPC_B_PARITY         2
`define UPC_F_FILL           1:0
`define UPC_B_UDIS           5
`define UPC_F_ADDR           4:0
`define UPC_B_ADDR_TOP       4
`define UPC_B_PLCP           4
`define UPC_B_TXSUM          1
`define UPC_B_RXSUM          0
`define UPC_B_LOCD           7
`define UPC_M_TXIND          8'hFC
`define UPC_M_RXIND          8'hEF
`define UPC_M_SUMEN          8'h13
`define UPC_B_PORTEN         0
`define UPC_B_CDEN           1
`define UPC_B_PINEN          2
`define UPC_B_UTOP16         3
`endif

// ### sim/upc_port_ctrl_props.sv
// Concurrent checks on the UTOPIA control and cell interrupt block ports.
// Assumes an APB master that holds each request until pready is sampled high.
module upc_port_ctrl_props (
    input wire logic        clock,
    input wire logic        arst_n,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [4:0]  tx_address_pins,
    input wire logic [4:0]  rx_address_pins,
    input wire logic        tx_port_selected,
    input wire logic        rx_port_selected,
    input wire logic        utopia_output_enable,
    input wire logic        tx_fifo_pointer_clear,
    input wire logic        rx_fifo_pointer_clear,
    input wire logic        parity_sense_select,
    input wire logic [2:0]  tx_fill_cells_minus_one,
    input wire logic        port_summary_status,
    input wire logic        irq_pin_n
);
    // ----------------------------------------
    // Write decode and properties
    // ----------------------------------------
    default clocking @(posedge clock); endclocking
    default disable iff (!arst_n);
    wire one_wr = psel && penable && pwrite && paddr == 12'h034;
    wire two_wr = psel && penable && pwrite && paddr == 12'h038;
    wire tx_req = one_wr && pwdata[7];
    wire rx_req = one_wr && pwdata[6];
    sequence s_one_wr; one_wr; endsequence
    AST_TX_CLEAR: assert property (s_one_wr ##0 tx_req |=> tx_fifo_pointer_clear) else $error("tx clear missing");
    AST_RX_CLEAR: assert property (s_one_wr ##0 rx_req |=> rx_fifo_pointer_clear) else $error("rx clear missing");
    AST_TX_PULSE: assert property (tx_fifo_pointer_clear |-> $past(tx_req)) else $error("tx clear unbidden");
    AST_RX_PULSE: assert property (rx_fifo_pointer_clear && !rx_req |=> !rx_fifo_pointer_clear)
        else $error("rx clear stuck");
    AST_PARITY: assert property (s_one_wr |=> parity_sense_select == $past(pwdata[2])) else $error("parity");
    AST_FILL: assert property (s_one_wr |=> tx_fill_cells_minus_one == {1'b0, $past(pwdata[1:0])})
        else $error("fill threshold");
    AST_OE_WRITE: assert property (!$stable(utopia_output_enable) |-> $past(two_wr)) else $error("oe moved");
    AST_SELECT: assert property (tx_address_pins == rx_address_pins |-> tx_port_selected == rx_port_selected)
        else $error("select mismatch");
    AST_PIN: assert property (!irq_pin_n |-> port_summary_status) else $error("pin without summary");
endmodule // upc_port_ctrl_props

bind upc_port_ctrl upc_port_ctrl_props u_props (.clock, .arst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
    .tx_address_pins, .rx_address_pins, .tx_port_selected, .rx_port_selected, .utopia_output_enable,
    .tx_fifo_pointer_clear, .rx_fifo_pointer_clear, .parity_sense_select, .tx_fill_cells_minus_one,
    .port_summary_status, .irq_pin_n);

// ### sim/upc_atm_model.sv
// Layer device model that polls one PHY address on the UTOPIA address pins.
// Assumes the bench names the polled address; receive polling trails transmit by one cycle.
module upc_atm_model (
    input  wire logic       clock,
    input  wire logic [4:0] target,
    output logic      [4:0] tx_address_pins = 5'h1F,
    output logic      [4:0] rx_address_pins = 5'h1F
);
    timeunit 1ns;
    timeprecision 1ps;
    always @(posedge clock) begin
        tx_address_pins <= target;
        rx_address_pins <= tx_address_pins;
    end
endmodule // upc_atm_model

// ### sim/testbench.sv
// Self-checking bench for the UTOPIA control and cell interrupt block.
// Assumes a zero-wait APB slave; status sources are driven by the bench.
`include "upc_map.vh"
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------
    // Stimulus, instances and bus tasks
    // ----------------------------------------
    localparam logic [3:0] PORT = 4'h5;
    logic clock = 1'b0, arst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [5:0] tx_status = 6'h00;
    logic [7:0] rx_status = 8'h00;
    logic [4:0] other_port_address = 5'h00, target = 5'h1F;
    logic other_port_valid = 1'b0, convergence_frame_irq = 1'b0;
    wire [4:0] tx_address_pins, rx_address_pins;
    wire [31:0] prdata;
    wire [7:0] rx_user_octet_two;
    wire [2:0] tx_fill_cells_minus_one;
    wire [1:0] tx_fill_threshold;
    wire pready, pslverr, tx_port_selected, rx_port_selected, utopia_output_enable, tx_fifo_pointer_clear;
    wire rx_fifo_pointer_clear, parity_sense_select, rx_user_octet_insert, delineator_port_irq;
    wire port_summary_status, irq_pin_n, bus_conflict_status;
    int failures = 0, n_compared = 0;
    always #2 clock = ~clock;
    upc_port_ctrl #(.PORT_INDEX(PORT)) dut (.clock, .arst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
        .prdata, .pslverr, .tx_status, .rx_status, .other_port_address, .other_port_valid, .convergence_frame_irq,
        .tx_address_pins, .rx_address_pins, .tx_port_selected, .rx_port_selected, .utopia_output_enable,
        .tx_fifo_pointer_clear, .rx_fifo_pointer_clear, .parity_sense_select, .tx_fill_threshold,
        .tx_fill_cells_minus_one, .rx_user_octet_two, .rx_user_octet_insert, .delineator_port_irq,
        .port_summary_status, .irq_pin_n, .bus_conflict_status);
    upc_atm_model u_atm (.clock, .target, .tx_address_pins, .rx_address_pins);
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd, output logic [7:0] rd);
        logic done;
        done = 1'b0;
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {2'b00, idx, 2'b00};
        pwdata <= {24'h000000, wd};
        @(posedge clock);
        penable <= 1'b1;
        // Sample mid-cycle: nothing moves before the access edge, so these are the edge values.
        while (!done) begin
            @(negedge clock);
            done = (pready === 1'b1);
            rd = prdata[7:0];
            @(posedge clock);
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] idx, input logic [7:0] wd);
        logic [7:0] d;
        apb(1'b1, idx, wd, d);
    endtask
    task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
        logic [7:0] d;
        apb(1'b0, idx, 8'h00, d);
        chk(d, exp);
    endtask
    task automatic settle;
        repeat (3) @(posedge clock);
        #1;
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_defaults;
        #1 chk(utopia_output_enable, 8'h00);
        chk(irq_pin_n, 8'h01);
        chk({pready, pslverr}, 8'h02);
        rd(`UPC_IDX_SUM_EN, 8'h00);
        rd(`UPC_IDX_UCTL_ONE, 8'h00);
        rd(`UPC_IDX_UCTL_TWO, {4'h2, PORT});
        rd(`UPC_IDX_UDF2, {4'h0, PORT});
        rd(`UPC_IDX_TXEN, 8'hFC);
        rd(`UPC_IDX_RXEN, 8'hFF);
        wr(8'h3F, 8'hAA);
        rd(8'h3F, 8'h00);
    endtask
    task automatic t_control;
        wr(`UPC_IDX_UCTL_ONE, 8'hC0);
        #1 chk({tx_fifo_pointer_clear, rx_fifo_pointer_clear}, 8'h03);
        @(posedge clock);
        #1 chk({tx_fifo_pointer_clear, rx_fifo_pointer_clear}, 8'h00);
        rd(`UPC_IDX_UCTL_ONE, 8'h00);
        // No cell traffic runs here, which stands in for the port being held in reset.
        for (int f = 0; f < 4; f++) begin
            wr(`UPC_IDX_UCTL_ONE, {5'h00, f[0], f[1:0]});
            rd(`UPC_IDX_UCTL_ONE, {5'h00, f[0], f[1:0]});
            chk({parity_sense_select, tx_fill_threshold, tx_fill_cells_minus_one}, {2'b00, f[0], f[1:0], 1'b0, f[1:0]});
        end
    endtask
    task automatic t_address;
        wr(`UPC_IDX_UCTL_TWO, 8'h0A);
        #1 chk(utopia_output_enable, 8'h01);
        @(posedge clock) target <= 5'h0A;
        settle;
        chk({tx_port_selected, rx_port_selected}, 8'h03);
        @(posedge clock) target <= 5'h1A;
        settle;
        chk({tx_port_selected, rx_port_selected}, 8'h00);
        wr(`UPC_IDX_PORTCTL, 8'h08);
        wr(`UPC_IDX_UDF2, 8'h5A);
        #1 chk({rx_user_octet_two[6:0], rx_user_octet_insert}, 8'hB5);
        chk(rx_user_octet_two, 8'h5A);
    endtask
    task automatic t_tx_irq;
        wr(`UPC_IDX_SUM_EN, 8'h13);
        wr(`UPC_IDX_PORTCTL, 8'h0F);
        @(posedge clock) tx_status <= 6'h20;
        settle;
        chk({delineator_port_irq, port_summary_status, irq_pin_n}, 8'h06);
        rd(`UPC_IDX_SUM_IND, 8'h02);
        rd(`UPC_IDX_TXIND, 8'h80);
        rd(`UPC_IDX_TXIND, 8'h00);
        rd(`UPC_IDX_SUM_IND, 8'h00);
        wr(`UPC_IDX_TXEN, 8'h7C);
        tx_status <= 6'h00;
        settle;
        @(posedge clock) tx_status <= 6'h20;
        settle;
        rd(`UPC_IDX_TXIND, 8'h00);
        wr(`UPC_IDX_TXEN, 8'hFC);
        other_port_valid <= 1'b1;
        other_port_address <= 5'h0A;
        settle;
        chk(bus_conflict_status, 8'h01);
        rd(`UPC_IDX_TXIND, 8'h04);
        @(posedge clock) convergence_frame_irq <= 1'b1;
        settle;
        rd(`UPC_IDX_SUM_IND, 8'h10);
        chk(irq_pin_n, 8'h00);
        wr(`UPC_IDX_PORTCTL, 8'h0B);
        #1 chk(irq_pin_n, 8'h01);
        wr(`UPC_IDX_PORTCTL, 8'h0F);
        wr(`UPC_IDX_SUM_EN, 8'h03);
        #1 chk(irq_pin_n, 8'h01);
    endtask
    task automatic t_rx_irq;
        for (int i = 0; i < 8; i++) begin
            @(posedge clock) rx_status <= 8'h01 << i;
            settle;
            rd(`UPC_IDX_RXIND, (i == 4) ? 8'h00 : 8'h01 << i);
            @(posedge clock) rx_status <= 8'h00;
            settle;
            rd(`UPC_IDX_RXIND, (i == 7) ? 8'h80 : 8'h00);
        end
    endtask
    task automatic t_reset;
        @(posedge clock) arst_n <= 1'b0;
        repeat (2) @(posedge clock);
        arst_n <= 1'b1;
        #1 chk(utopia_output_enable, 8'h00);
        rd(`UPC_IDX_UCTL_TWO, {4'h2, PORT});
        rd(`UPC_IDX_UDF2, {4'h0, PORT});
    endtask
    task automatic finish_test;
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge clock);
        arst_n <= 1'b1;
        t_defaults;
        t_control;
        t_address;
        t_tx_irq;
        t_rx_irq;
        t_reset;
        finish_test;
    end
    // The whole run needs well under 2000 cycles; this bound only cuts a hang.
    initial begin
        #20us;
        failures++;
        finish_test;
    end
endmodule // testbench
